// ---- rtl/rcs_cfg.svh ----
// Purpose: constants for the reset and clock sequencer
// Assumes: clk_sys is the input clock, 250 MHz
// Notes: offsets are byte addresses on the register bus
`ifndef RCS_CFG_SVH
`define RCS_CFG_SVH

// clock and timing
`define RCS_CLK_PERIOD_NS        4
`define RCS_STRETCH_CYCLES       10'h200
`define RCS_STRETCH_CNT_W        10
`define RCS_RELAUNCH_MAX_P       6
`define RCS_NMI_MIN_P            3'h2
`define RCS_EXT_MIN_P            3'h4
`define RCS_IRQ_LINES            5

// register map
`define RCS_ADDR_W               8
`define RCS_OFS_CTRL             8'h00
`define RCS_OFS_STATUS           8'h04
`define RCS_OFS_IRQERR           8'h08

// control fields
`define RCS_CTRL_SRCSEL_BIT      0
`define RCS_CTRL_PLLEN_BIT       1
`define RCS_CTRL_RESET           2'h0

// status fields
`define RCS_ST_PHASE_LSB         0
`define RCS_ST_BYPASS_BIT        3
`define RCS_ST_BOOT_LSB          4
`define RCS_ST_ENDIAN_BIT        6
`define RCS_ST_CLKSRC_BIT        7

`endif

// ---- rtl/rcs_clkdiv.sv ----
// Purpose: free-running divide-by-8 phase counter
// Assumes: one clock domain
// Notes: bit n of the count is a divide-by-2^(n+1) level
`timescale 1ns/10ps
module rcs_clkdiv
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset,
	// divider phase
	output logic      [2:0] div_cnt_ff
);

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			div_cnt_ff <= 3'h0;
		else
			div_cnt_ff <= div_cnt_ff + 3'h1;
	end

endmodule

// ---- rtl/rcs_pkg.sv ----
// Purpose: types for the reset and clock sequencer
// Assumes: nothing
// Notes: phase codes are one-hot
package rcs_pkg;

	typedef enum logic [2:0]
	{
		RCS_PH_ASSERT  = 3'h1,
		RCS_PH_STRETCH = 3'h2,
		RCS_PH_RUN     = 3'h4
	} rcs_phase_e;

	typedef logic [31:0] rcs_word_t;

endpackage

// ---- rtl/rcs_top.sv ----
// Purpose: device reset sequencing, clock ratios, pin group enables
// Assumes: clk_sys is the input clock; pins are asynchronous
// Notes: clocks leave as levels or one-cycle enables
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
`include "rcs_cfg.svh"
module rcs_top
(
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     reset,
	// board reset and straps
	input  wire logic                     ext_reset_n,
	input  wire logic               [1:0] boot_mode_strap,
	input  wire logic                     endianness_strap,
	input  wire logic                     input_clock_source_strap,
	// interrupt pins
	input  wire logic                     nmi_pin,
	input  wire logic               [3:0] ext_int_pin,
	// avalon-mm slave
	input  wire logic [`RCS_ADDR_W-1:0]   avs_address,
	input  wire logic                     avs_read,
	input  wire logic                     avs_write,
	input  wire logic              [31:0] avs_writedata,
	output logic                   [31:0] avs_readdata,
	output logic                          avs_waitrequest,
	// memory interface bus request
	input  wire logic                     bus_request_in,
	output logic                          bus_request_out,
	output logic                          bus_request_valid,
	// internal clocks
	output logic                          core_clock_en,
	output logic                          peripheral_clock_en,
	output logic                          memif_internal_clock_en,
	// clock pins
	output logic                          memif_clock_out,
	output logic                          memif_clock_out_oe,
	output logic                          second_clock_out,
	output logic                          second_clock_out_oe,
	output logic                          third_clock_out,
	// pin group enables and reset state
	output logic                          memif_group_oe,
	output logic                          serial_timer_group_oe,
	output logic                          internal_reset_out,
	output logic                          pll_bypass_out,
	// latched straps
	output logic                    [1:0] boot_mode_latched,
	output logic                          endianness_latched,
	// qualified interrupt events
	output logic [`RCS_IRQ_LINES-1:0]     irq_event
);

	// pin synchronisers, three stages
	logic                        rst_s1_ff, rst_s2_ff, rst_s3_ff, rst_n_ff;
	logic                  [3:0] strap_s1_ff, strap_s2_ff, strap_s3_ff;
	logic [`RCS_IRQ_LINES-1:0]   irq_s1_ff, irq_s2_ff, irq_s3_ff, irq_lvl_ff;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rst_s1_ff   <= 1'b0;
			rst_s2_ff   <= 1'b0;
			rst_s3_ff   <= 1'b0;
			strap_s1_ff <= 4'h0;
			strap_s2_ff <= 4'h0;
			strap_s3_ff <= 4'h0;
			irq_s1_ff   <= 5'h00;
			irq_s2_ff   <= 5'h00;
			irq_s3_ff   <= 5'h00;
		end
		else
		begin
			rst_s1_ff   <= ext_reset_n;
			rst_s2_ff   <= rst_s1_ff;
			rst_s3_ff   <= rst_s2_ff;
			strap_s1_ff <= {input_clock_source_strap, endianness_strap, boot_mode_strap};
			strap_s2_ff <= strap_s1_ff;
			strap_s3_ff <= strap_s2_ff;
			irq_s1_ff   <= {ext_int_pin, nmi_pin};
			irq_s2_ff   <= irq_s1_ff;
			irq_s3_ff   <= irq_s2_ff;
		end
	end

	// accepted pin levels: second and third stage agree
	wire                        rst_agree   = (rst_s2_ff == rst_s3_ff);
	wire                        rst_rise    = rst_agree & rst_s3_ff & ~rst_n_ff;
	wire                        rst_fall    = rst_agree & ~rst_s3_ff & rst_n_ff;
	wire [`RCS_IRQ_LINES-1:0]   irq_agree   = ~(irq_s2_ff ^ irq_s3_ff);
	wire [`RCS_IRQ_LINES-1:0]   nxt_irq_lvl = (irq_agree & irq_s3_ff) | (~irq_agree & irq_lvl_ff);

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			rst_n_ff   <= 1'b0;
			irq_lvl_ff <= 5'h00;
		end
		else
		begin
			rst_n_ff   <= rst_agree ? rst_s3_ff : rst_n_ff;
			irq_lvl_ff <= nxt_irq_lvl;
		end
	end

	// reset phase machine
	rcs_pkg::rcs_phase_e            phase_ff, nxt_phase;
	logic [`RCS_STRETCH_CNT_W-1:0]  stretch_cnt_ff;
	logic [`RCS_STRETCH_CNT_W-1:0]  nxt_stretch_cnt;
	logic                           strap_take;

	wire stretch_done = (stretch_cnt_ff == `RCS_STRETCH_CYCLES - `RCS_STRETCH_CNT_W'(1));

	always_comb
	begin
		nxt_phase       = phase_ff;
		nxt_stretch_cnt = stretch_cnt_ff;
		strap_take      = 1'b0;
		case (phase_ff)
			rcs_pkg::RCS_PH_ASSERT:
			begin
				if (rst_rise)
				begin
					nxt_phase       = rcs_pkg::RCS_PH_STRETCH;
					nxt_stretch_cnt = '0;
					strap_take      = 1'b1;
				end
			end
			rcs_pkg::RCS_PH_STRETCH:
			begin
				if (rst_fall)
					nxt_phase = rcs_pkg::RCS_PH_ASSERT;
				else if (stretch_done)
					nxt_phase = rcs_pkg::RCS_PH_RUN;
				else
					nxt_stretch_cnt = stretch_cnt_ff + `RCS_STRETCH_CNT_W'(1);
			end
			rcs_pkg::RCS_PH_RUN:
			begin
				if (rst_fall)
					nxt_phase = rcs_pkg::RCS_PH_ASSERT;
			end
			default:
				nxt_phase = rcs_pkg::RCS_PH_ASSERT;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			phase_ff       <= rcs_pkg::RCS_PH_ASSERT;
			stretch_cnt_ff <= '0;
		end
		else
		begin
			phase_ff       <= nxt_phase;
			stretch_cnt_ff <= nxt_stretch_cnt;
		end
	end

	// strap latch
	logic [3:0] strap_ff;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			strap_ff <= 4'h0;
		else if (strap_take)
			strap_ff <= strap_s3_ff;
	end

	wire in_assert = (phase_ff == rcs_pkg::RCS_PH_ASSERT);
	wire in_run    = (phase_ff == rcs_pkg::RCS_PH_RUN);

	// clock ratios
	logic [2:0] div_cnt;

	rcs_clkdiv u_div
	(
		.clk_sys    (clk_sys),
		.reset      (reset),
		.div_cnt_ff (div_cnt)
	);

	wire div8_tick = (div_cnt == 3'h7);
	wire div2_tick = div_cnt[0];
	wire nxt_core_en   = in_run ? 1'b1 : div8_tick;
	wire nxt_periph_en = in_run ? div2_tick : div8_tick;
	wire int_memif_lvl = in_run ? div_cnt[0] : div_cnt[2];
	wire alt_memif_lvl = div_cnt[1];

	// control registers
	logic [1:0] ctrl_ff;
	logic [`RCS_IRQ_LINES-1:0] irq_err_ff;

	wire src_sel  = ctrl_ff[`RCS_CTRL_SRCSEL_BIT];
	wire pll_en   = ctrl_ff[`RCS_CTRL_PLLEN_BIT];
	wire nxt_memif_clk   = src_sel ? alt_memif_lvl : int_memif_lvl;
	wire nxt_third_clk   = in_assert ? 1'b0 : div_cnt[2];
	wire nxt_second_clk  = in_run ? div_cnt[0] : div_cnt[2];

	// clock pins and enables
	logic memif_clk_ff, second_clk_ff, third_clk_ff;
	logic core_en_ff, periph_en_ff, memif_en_ff;

	wire memif_rise = nxt_memif_clk & ~memif_clk_ff;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			memif_clk_ff  <= 1'b0;
			second_clk_ff <= 1'b0;
			third_clk_ff  <= 1'b0;
			core_en_ff    <= 1'b0;
			periph_en_ff  <= 1'b0;
			memif_en_ff   <= 1'b0;
		end
		else
		begin
			memif_clk_ff  <= nxt_memif_clk;
			second_clk_ff <= nxt_second_clk;
			third_clk_ff  <= nxt_third_clk;
			core_en_ff    <= nxt_core_en;
			periph_en_ff  <= nxt_periph_en;
			memif_en_ff   <= nxt_periph_en;
		end
	end

	assign core_clock_en           = core_en_ff;
	assign peripheral_clock_en     = periph_en_ff;
	assign memif_internal_clock_en = memif_en_ff;
	assign memif_clock_out         = memif_clk_ff;
	assign memif_clock_out_oe      = ~in_assert;
	assign second_clock_out        = second_clk_ff;
	assign second_clock_out_oe     = ~in_assert;
	assign third_clock_out         = third_clk_ff;

	// pin groups follow internal reset
	assign memif_group_oe        = in_run;
	assign serial_timer_group_oe = in_run;
	assign internal_reset_out    = ~in_run;
	assign pll_bypass_out        = ~(in_run & pll_en);
	assign boot_mode_latched     = strap_ff[1:0];
	assign endianness_latched    = strap_ff[2];

	// bus request stepped by memif clock
	logic bus_request_out_ff;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			bus_request_out_ff <= 1'b0;
		else if (!in_run)
			bus_request_out_ff <= 1'b0;
		else if (memif_rise)
			bus_request_out_ff <= bus_request_in;
	end

	assign bus_request_out   = bus_request_out_ff;
	assign bus_request_valid = in_run;

	// interrupt width monitor, counted in core clock periods
	function automatic logic [2:0] min_width(input int idx);
		min_width = (idx == 0) ? `RCS_NMI_MIN_P : `RCS_EXT_MIN_P;
	endfunction

	logic [2:0] width_cnt_ff [`RCS_IRQ_LINES];
	logic [`RCS_IRQ_LINES-1:0] irq_event_ff;
	logic [`RCS_IRQ_LINES-1:0] width_err;
	logic [`RCS_IRQ_LINES-1:0] width_ok;

	always_comb
	begin
		for (int i = 0; i < `RCS_IRQ_LINES; i++)
		begin
			width_ok[i]  = (width_cnt_ff[i] >= min_width(i));
			width_err[i] = (nxt_irq_lvl[i] != irq_lvl_ff[i]) & ~width_ok[i];
		end
	end

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			for (int i = 0; i < `RCS_IRQ_LINES; i++)
				width_cnt_ff[i] <= 3'h0;
			irq_event_ff <= 5'h00;
		end
		else
		begin
			for (int i = 0; i < `RCS_IRQ_LINES; i++)
			begin
				if (nxt_irq_lvl[i] != irq_lvl_ff[i])
					width_cnt_ff[i] <= 3'h1;
				else if (core_en_ff && width_cnt_ff[i] != 3'h7)
					width_cnt_ff[i] <= width_cnt_ff[i] + 3'h1;
				irq_event_ff[i] <= nxt_irq_lvl[i] & ~irq_lvl_ff[i] & width_ok[i] & in_run;
			end
		end
	end

	assign irq_event = irq_event_ff;

	// avalon-mm slave, one wait state
	logic        ack_ff;
	logic [31:0] rdata_ff;

	wire req      = avs_read | avs_write;
	wire hit_ctrl = (avs_address == `RCS_OFS_CTRL);
	wire hit_st   = (avs_address == `RCS_OFS_STATUS);
	wire hit_err  = (avs_address == `RCS_OFS_IRQERR);
	wire wr_now   = avs_write & ack_ff;

	wire [31:0] status_word = {24'h000000, strap_ff[3], strap_ff[2], strap_ff[1:0],
	                           pll_bypass_out, phase_ff};
	wire [31:0] rd_mux = hit_ctrl ? {30'h00000000, ctrl_ff} :
	                     hit_st   ? status_word :
	                     hit_err  ? {27'h0000000, irq_err_ff} :
	                                32'h00000000;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h00000000;
		end
		else
		begin
			ack_ff   <= req & ~ack_ff;
			rdata_ff <= rd_mux;
		end
	end

	assign avs_waitrequest = req & ~ack_ff;
	assign avs_readdata    = rdata_ff;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			ctrl_ff <= `RCS_CTRL_RESET;
		else if (in_assert)
			ctrl_ff[`RCS_CTRL_PLLEN_BIT] <= 1'b0;
		else if (wr_now && hit_ctrl)
			ctrl_ff <= avs_writedata[1:0];
	end

	// width errors: sticky, write one to clear, set wins
	wire [`RCS_IRQ_LINES-1:0] err_clr = (wr_now && hit_err) ? avs_writedata[`RCS_IRQ_LINES-1:0] : 5'h00;

	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
			irq_err_ff <= 5'h00;
		else
			irq_err_ff <= (irq_err_ff & ~err_clr) | width_err;
	end

endmodule

// ---- tb/rcs_board.sv ----
// Purpose: board model: reset pin, straps, interrupt sources
// Assumes: bench calls the tasks just after a rising edge
// Notes: straps flip once their hold time is over
`timescale 1ns/10ps
module rcs_board
(
	// clock
	input  wire logic       clk_sys,
	// reset pin and straps
	output logic            ext_reset_n,
	output logic      [1:0] boot_mode_strap,
	output logic            endianness_strap,
	output logic            input_clock_source_strap,
	// interrupt sources
	output logic            nmi_pin,
	output logic      [3:0] ext_int_pin
);
	logic [4:0] irq_ff;

	assign nmi_pin     = irq_ff[0];
	assign ext_int_pin = irq_ff[4:1];

	initial
	begin
		ext_reset_n              = 1'b0;
		boot_mode_strap          = 2'h0;
		endianness_strap         = 1'b0;
		input_clock_source_strap = 1'b1;
		irq_ff                   = 5'h00;
	end

	// pin low, straps set up long before release
	task automatic pin_low(input logic [1:0] boot, input logic endian);
		ext_reset_n      <= 1'b0;
		boot_mode_strap  <= boot;
		endianness_strap <= endian;
	endtask

	task automatic pin_high();
		ext_reset_n <= 1'b1;
	endtask

	// called well past the 2P hold
	task automatic straps_off();
		boot_mode_strap  <= ~boot_mode_strap;
		endianness_strap <= ~endianness_strap;
	endtask

	// high for width cycles, then a long low
	task automatic irq_pulse(input int line, input int width);
		@(posedge clk_sys);
		irq_ff[line] <= 1'b1;
		repeat (width) @(posedge clk_sys);
		irq_ff[line] <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask
endmodule

// ---- tb/rcs_top_asserts.sv ----
// Purpose: port checker for the sequencer
// Assumes: one clock, reset active high
// Notes: bound to rcs_top below
`timescale 1ns/10ps
module rcs_top_asserts
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// watched ports
	input wire logic ext_reset_n,
	input wire logic bus_request_out,
	input wire logic bus_request_valid,
	input wire logic core_clock_en,
	input wire logic memif_clock_out,
	input wire logic memif_clock_out_oe,
	input wire logic second_clock_out_oe,
	input wire logic third_clock_out,
	input wire logic memif_group_oe,
	input wire logic serial_timer_group_oe,
	input wire logic internal_reset_out,
	input wire logic pll_bypass_out
);
	logic [10:0] stretch_ff;

	// cycles spent in the stretch phase
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			stretch_ff <= 11'h000;
		else
			stretch_ff <= (memif_clock_out_oe && internal_reset_out) ? stretch_ff + 11'h001 : 11'h000;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	chk_groups_off: assert property (
		internal_reset_out |-> !memif_group_oe && !serial_timer_group_oe && !bus_request_valid)
		else $error("pin groups driven in reset");
	chk_groups_on: assert property (
		!internal_reset_out |-> memif_group_oe && serial_timer_group_oe && bus_request_valid)
		else $error("pin groups off in run");
	chk_core_full: assert property (
		!internal_reset_out && !$past(internal_reset_out) |-> core_clock_en)
		else $error("core clock not full rate");
	chk_core_div8: assert property (
		internal_reset_out && $past(internal_reset_out) && core_clock_en
		|=> (!core_clock_en || !internal_reset_out)[*7] ##1 (core_clock_en || !internal_reset_out))
		else $error("core clock not divide by 8");
	chk_bypass_rst: assert property (
		internal_reset_out |-> pll_bypass_out)
		else $error("pll not bypassed in reset");
	chk_bus_request_out_edge: assert property (
		bus_request_valid && $past(bus_request_valid) && $changed(bus_request_out) |-> $rose(memif_clock_out))
		else $error("bus request off memif edge");
	chk_clk_float: assert property (
		!ext_reset_n [*6] |-> !memif_clock_out_oe && !second_clock_out_oe && !third_clock_out)
		else $error("clock pins not parked");
	chk_clk_return: assert property (
		ext_reset_n [*6] |-> memif_clock_out_oe && second_clock_out_oe)
		else $error("clock pins not back");
	chk_stretch_len: assert property (
		$fell(internal_reset_out) |-> stretch_ff == 11'h200)
		else $error("stretch length wrong");
endmodule

bind rcs_top rcs_top_asserts chk_u (.*);

// ---- tb/rcs_top_test.sv ----
// Purpose: self-checking bench for the sequencer
// Assumes: board model drives pins, bench drives the bus
// Notes: fixed seed
`timescale 1ns/10ps
`include "rcs_cfg.svh"
module rcs_top_test;
	localparam int SYNC_LAT = 4;
	logic             clk_sys, reset, ext_reset_n, endianness_strap, input_clock_source_strap, nmi_pin;
	logic       [1:0] boot_mode_strap, boot_mode_latched, b;
	logic       [3:0] ext_int_pin;
	logic       [4:0] irq_event, irq_seen;
	logic       [7:0] avs_address;
	logic      [31:0] avs_writedata, avs_readdata, q;
	logic             avs_read, avs_write, avs_waitrequest, bus_request_in, bus_request_out, bus_request_valid;
	logic             core_clock_en, peripheral_clock_en, memif_internal_clock_en, memif_clock_out, e;
	logic             memif_clock_out_oe, second_clock_out, second_clock_out_oe, third_clock_out, memif_group_oe;
	logic             serial_timer_group_oe, internal_reset_out, pll_bypass_out, endianness_latched, br_rand, irq_clr;
	int               n_errors, checked, cyc, n, i;

	rcs_top dut_u (.*);
	rcs_board board_u (.*);

	always #2 clk_sys = ~clk_sys;

	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		bus_request_in <= br_rand ? 1'($urandom) : 1'b1;
		irq_seen <= irq_clr ? 5'h00 : irq_seen | irq_event;
		if (cyc == 20000)
		begin
			n_errors++;
			results();
		end
	end

	task automatic results();
		if (n_errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	function automatic int ticks(input int div);
		return 64 / div;
	endfunction

	function automatic logic [31:0] exp_status(input logic [1:0] bm, input logic en);
		return 32'(rcs_pkg::RCS_PH_RUN) | (32'h1 << `RCS_ST_BYPASS_BIT) | (32'(bm) << `RCS_ST_BOOT_LSB)
			| (32'(en) << `RCS_ST_ENDIAN_BIT) | (32'h1 << `RCS_ST_CLKSRC_BIT);
	endfunction

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		logic w;
		int   k;
		k = 0;
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		do
		begin
			@(posedge clk_sys);
			w  = avs_waitrequest;
			rd = avs_readdata;
			k++;
		end
		while (w !== 1'b0 && k < 40);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		chk(w, 1'b0);
	endtask

	// clock ratios over 64 input clocks
	task automatic measure(input int dc, input int dp, input int dm);
		int         c = 0, p = 0, m = 0, mo = 0, so = 0, to = 0;
		logic [2:0] pv;
		pv = {memif_clock_out, second_clock_out, third_clock_out};
		repeat (64)
		begin
			@(posedge clk_sys);
			c += core_clock_en;
			p += peripheral_clock_en;
			m += memif_internal_clock_en;
			mo += memif_clock_out & ~pv[2];
			so += second_clock_out & ~pv[1];
			to += third_clock_out & ~pv[0];
			pv = {memif_clock_out, second_clock_out, third_clock_out};
		end
		chk(c, ticks(dc));
		chk(p, ticks(dp));
		chk(m, ticks(dp));
		chk(mo, ticks(dm));
		chk(so, ticks(dp));
		chk(to, ticks(8));
	endtask

	initial
	begin
		clk_sys = 1'b0;
		reset = 1'b1;
		{avs_address, avs_writedata, avs_read, avs_write} = '0;
		{br_rand, irq_clr} = '0;
		void'($urandom(10512));
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			b = 2'(i);
			e = 1'($urandom);
			board_u.pin_low(b, e);
			repeat (30 + $urandom % 20) @(posedge clk_sys);
			board_u.pin_high();
			n = 0;
			while (internal_reset_out !== 1'b0 && n < 2000)
			begin
				@(posedge clk_sys);
				n++;
			end
			chk(n, SYNC_LAT + 513);
			chk(boot_mode_latched, b);
			chk(endianness_latched, e);
			board_u.straps_off();
			bus(1'b0, `RCS_OFS_STATUS, 32'h0, q);
			chk(q, exp_status(b, e));
			measure(1, 2, 2);
		end
		bus(1'b0, `RCS_OFS_CTRL, 32'h0, q);
		chk(q, 32'h0);
		bus(1'b1, `RCS_OFS_CTRL, 32'h1, q);
		measure(1, 2, 4);
		bus(1'b1, `RCS_OFS_CTRL, 32'h2, q);
		repeat (2) @(posedge clk_sys);
		chk(pll_bypass_out, 1'b0);
		bus(1'b0, 8'(($urandom % 61 + 3) * 4), 32'h0, q);
		chk(q, 32'h0);
		br_rand <= 1'b1;
		repeat (200) @(posedge clk_sys);
		br_rand <= 1'b0;
		repeat (8) @(posedge clk_sys);
		chk(bus_request_out, 1'b1);
		for (i = 0; i < 5; i++)
		begin
			irq_clr <= 1'b1;
			@(posedge clk_sys);
			irq_clr <= 1'b0;
			board_u.irq_pulse(i, 8);
			chk(irq_seen, 5'h01 << i);
		end
		board_u.irq_pulse(0, 2);
		board_u.irq_pulse(2, 4);
		bus(1'b0, `RCS_OFS_IRQERR, 32'h0, q);
		chk(q, 32'h0);
		board_u.irq_pulse(1, 3);
		bus(1'b0, `RCS_OFS_IRQERR, 32'h0, q);
		chk(q, 32'h2);
		bus(1'b1, `RCS_OFS_IRQERR, 32'h2, q);
		bus(1'b0, `RCS_OFS_IRQERR, 32'h0, q);
		chk(q, 32'h0);
		board_u.pin_low(2'h0, 1'b0);
		repeat (8) @(posedge clk_sys);
		chk({memif_group_oe, serial_timer_group_oe, memif_clock_out_oe, second_clock_out_oe, third_clock_out}, 32'h0);
		bus(1'b0, `RCS_OFS_CTRL, 32'h0, q);
		chk(q, 32'h0);
		board_u.pin_high();
		repeat (12) @(posedge clk_sys);
		measure(8, 8, 8);
		results();
	end
endmodule
